/* core/drive_control_status_word_logic.sv */
// Drive command word decoder and state word builder
//
// Contract
// - Word control active only for mode 1..3
// - Control-only presets ignore bus reference
// - Bits 4..6 select table reference index
// - Bit 7 rising edge clears fault
// - Bit 8 selects curve set if bus; ignored in servo builds
// - Bits 9..10 select user set if bus; ignored in servo builds
// - Four user sets, switch only in standby
// - Bits 13..15 drive outputs two..zero
// - Command bytes 2..5 signed Q16 reference
// - Status bytes 2..5 signed Q16 actual
// - Status bit 4 never asserted
// - Status bit 7 flags warning
// - Status bit 9 flags remote parameters
// - Status bit 10 flags reference reached
// - Status bits 12..15 report inputs three..zero
// - Enable starts power, open loop needs ref>0
// - Enable low ramps down or coasts; here it drops to switched on, power off at once, no ramp or coast stop
// - Servo without ramp brakes under torque
// - Emergency stop ramps, holds zero speed; no hold in open loop V/f unless servo
// - Table selection blocks direct bus reference
// - Bits 0..3,7 decode state commands
// - Status bits encode current drive state
`timescale 1ns/100ps
`include "drive_word_params.svh"
module drive_control_status_word_logic #(
  parameter int USER_SETS = 4,
  parameter bit SERVO = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Process data from the master
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte0,
  input wire logic [7:0] cmd_byte1,
  input wire logic [7:0] cmd_byte2,
  input wire logic [7:0] cmd_byte3,
  input wire logic [7:0] cmd_byte4,
  input wire logic [7:0] cmd_byte5,
  input wire logic system_started,
  // Settings
  input wire logic [7:0] bus_control_mode_setting,
  input wire logic bus_reference_enabled,
  input wire logic [3:0] reference_source_setting,
  input wire logic [3:0] curve_set_source_setting,
  input wire logic [3:0] user_set_source_setting,
  input wire logic [3:0] output_zero_function,
  input wire logic [3:0] output_one_function,
  input wire logic [3:0] output_two_function,
  input wire logic open_loop_volt_freq_mode,
  input wire logic stop_ramp_enabled,
  // Drive core feedback
  input wire logic fault_present,
  input wire logic warning_present,
  input wire logic remote_possible,
  input wire logic reference_reached,
  input wire logic limit_active,
  input wire logic stop_done,
  input wire logic [31:0] actual_value,
  input wire logic digital_input_zero,
  input wire logic digital_input_one,
  input wire logic digital_input_two,
  input wire logic digital_input_three,
  // Drive core control
  output logic power_stage_on,
  output logic ramp_stop,
  output logic coast_stop,
  output logic torque_brake,
  output logic hold_zero_speed,
  output logic fault_clear,
  output logic [31:0] bus_reference,
  output logic bus_reference_valid,
  output logic [2:0] table_ref_index,
  output logic table_ref_active,
  output logic curve_set_select,
  output logic [1:0] active_user_set,
  output logic digital_output_zero,
  output logic digital_output_one,
  output logic digital_output_two,
  // Status message
  output drive_word_pkg::word_type state_word,
  output drive_word_pkg::ref_type actual_word
);
  import drive_word_pkg::*;

  // ****************************************
  // Command decode
  // ****************************************
  word_type cmd_reg;
  word_type cmd_next;
  ref_type ref_reg;
  ref_type ref_next;
  logic cmd_valid_reg;
  logic cmd_valid_next;
  logic word_mode;
  word_type cmd;
  logic table_sel;
  logic fault_rise;
  logic cmd_shutdown;
  logic cmd_power_up;
  logic cmd_dis_power;
  logic cmd_estop;
  logic cmd_dis_oper;
  logic cmd_en_oper;
  logic ref_positive;

  assign cmd = {cmd_byte1, cmd_byte0};
  assign word_mode = (bus_control_mode_setting >= `MODE_MIN) &&
                     (bus_control_mode_setting <= `MODE_MAX);
  assign table_sel = (reference_source_setting == `REF_SRC_TABLE);
  // Bits 11 and 12 are never looked at
  // Latched word only: live bytes go stale after the strobe
  assign cmd_dis_power = ~cmd_reg[`CMD_DIS_POWER];
  assign cmd_estop = cmd_reg[`CMD_DIS_POWER] & ~cmd_reg[`CMD_ESTOP_N];
  assign cmd_shutdown = cmd_reg[2:0] == 3'h6;
  assign cmd_power_up = cmd_reg[2:0] == 3'h7;
  assign cmd_dis_oper = cmd_reg[3:0] == 4'h7;
  assign cmd_en_oper = cmd_reg[3:0] == 4'hF;

  // Fault reset acts only on the edge, not the level
  rise_detect rise_detect_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level(cmd_valid_reg & word_mode & cmd_reg[`CMD_FAULT_RST]),
    .rise(fault_rise)
  );

  // ****************************************
  // Latched command word and reference
  // ****************************************

  always_comb begin
    cmd_next = cmd_reg;
    ref_next = ref_reg;
    cmd_valid_next = cmd_valid_reg;
    if (cmd_valid && word_mode) begin
      cmd_next = cmd;
      cmd_valid_next = 1'b1;
      // Lowest byte first, signed Q16
      ref_next = {cmd_byte5, cmd_byte4, cmd_byte3, cmd_byte2};
    end
    if (!word_mode) begin
      cmd_valid_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd_reg <= `WORD_RESET;
      ref_reg <= `REF_RESET;
      cmd_valid_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      ref_reg <= ref_next;
      cmd_valid_reg <= cmd_valid_next;
    end
  end

  assign ref_positive = ~ref_reg[31] && (ref_reg != 32'h00000000);

  // ****************************************
  // Drive state machine
  // ****************************************
  drive_state_type state_reg;
  drive_state_type state_next;
  logic act;

  assign act = cmd_valid_reg & system_started;

  always_comb begin
    state_next = state_reg;
    if (fault_present && state_reg != ST_FAULT) begin
      state_next = (state_reg == ST_OPER) ? ST_FAULT_RESP : ST_FAULT;
    end else begin
      unique case (state_reg)
        ST_NOT_READY: begin
          state_next = ST_INHIBIT;
        end
        ST_INHIBIT: begin
          if (act && cmd_shutdown) begin
            state_next = ST_READY;
          end
        end
        ST_READY: begin
          if (act && cmd_dis_power) begin
            state_next = ST_INHIBIT;
          end else if (act && cmd_power_up) begin
            state_next = ST_ON;
          end
        end
        ST_ON: begin
          if (act && cmd_dis_power) begin
            state_next = ST_INHIBIT;
          end else if (act && cmd_shutdown) begin
            state_next = ST_READY;
          end else if (act && cmd_estop) begin
            state_next = ST_INHIBIT;
          end else if (act && cmd_en_oper &&
                       (!open_loop_volt_freq_mode || SERVO ||
                        ref_positive)) begin
            state_next = ST_OPER;
          end
        end
        ST_OPER: begin
          if (act && cmd_dis_power) begin
            state_next = ST_INHIBIT;
          end else if (act && cmd_estop) begin
            state_next = ST_ESTOP;
          end else if (act && cmd_shutdown) begin
            state_next = ST_READY;
          end else if (act && cmd_dis_oper) begin
            state_next = ST_ON;
          end
        end
        ST_ESTOP: begin
          // Only a cleared bit 1 (disable power) or a fault leaves the hold
          if (act && cmd_dis_power) begin
            state_next = ST_INHIBIT;
          end
        end
        ST_FAULT_RESP: begin
          if (stop_done) begin
            state_next = ST_FAULT;
          end
        end
        ST_FAULT: begin
          // A fault still standing wins over the reset edge
          if (fault_rise && !fault_present) begin
            state_next = ST_INHIBIT;
          end
        end
        default: begin
          state_next = ST_NOT_READY;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= ST_NOT_READY;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Drive control outputs
  // ****************************************
  logic stopping;
  logic standby;

  assign stopping = (state_reg == ST_ESTOP) || (state_reg == ST_FAULT_RESP);
  assign standby = ~power_stage_on;
  assign power_stage_on = (state_reg == ST_OPER) || stopping;
  assign ramp_stop = stopping & stop_ramp_enabled;
  assign coast_stop = stopping & ~stop_ramp_enabled & ~SERVO;
  assign torque_brake = stopping & ~stop_ramp_enabled & SERVO;
  assign hold_zero_speed = (state_reg == ST_ESTOP) & stop_done &
                           (SERVO | ~open_loop_volt_freq_mode);
  assign fault_clear = fault_rise;
  assign table_ref_active = word_mode & table_sel;
  assign table_ref_index = table_sel ? cmd_reg[6:4] : 3'h0;
  assign bus_reference_valid = cmd_valid_reg & bus_reference_enabled &
                               ~table_sel;
  assign bus_reference = bus_reference_valid ? ref_reg : 32'h00000000;

  // ****************************************
  // Data sets and digital outputs
  // ****************************************
  logic curve_reg;
  logic curve_next;
  logic [1:0] user_reg;
  logic [1:0] user_next;
  logic [2:0] dout_reg;
  logic [2:0] dout_next;
  logic [3:0] out_fn [3];
  logic [1:0] user_req;

  assign out_fn[0] = output_zero_function;
  assign out_fn[1] = output_one_function;
  assign out_fn[2] = output_two_function;
  assign user_req = cmd_reg[`CMD_USER_LSB +: 2];

  always_comb begin
    curve_next = curve_reg;
    user_next = user_reg;
    if (cmd_valid_reg && !SERVO) begin
      if (curve_set_source_setting == `CURVE_SRC_BUS) begin
        curve_next = cmd_reg[`CMD_CURVE_SET];
      end
      if (user_set_source_setting == `USER_SRC_BUS && standby &&
          32'(user_req) < USER_SETS) begin
        user_next = user_req;
      end
    end
  end

  // Bit 15 feeds output zero, bit 13 output two
  generate
    for (genvar i = 0; i < 3; i++) begin : g_dout
      always_comb begin
        // Outputs not owned by the bus are left low here
        dout_next[i] = 1'b0;
        if (out_fn[i] == `OUT_FN_BUS) begin
          dout_next[i] = cmd_valid_reg & cmd_reg[`CMD_DOUT_ZERO - i];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      curve_reg <= 1'b0;
      user_reg <= 2'h0;
      dout_reg <= 3'h0;
    end else begin
      curve_reg <= curve_next;
      user_reg <= user_next;
      dout_reg <= dout_next;
    end
  end

  assign curve_set_select = curve_reg;
  assign active_user_set = user_reg;
  assign digital_output_zero = dout_reg[0];
  assign digital_output_one = dout_reg[1];
  assign digital_output_two = dout_reg[2];

  // ****************************************
  // Status message
  // ****************************************
  word_type sw_next;
  word_type sw_reg;
  ref_type act_reg;

  always_comb begin
    sw_next = `WORD_RESET;
    unique case (state_reg)
      ST_NOT_READY: sw_next[6:0] = 7'h00;
      ST_INHIBIT: sw_next[6:0] = 7'h40;
      ST_READY: sw_next[6:0] = 7'h21;
      ST_ON: sw_next[6:0] = 7'h23;
      ST_OPER: sw_next[6:0] = 7'h27;
      ST_FAULT: sw_next[6:0] = 7'h08;
      ST_FAULT_RESP: sw_next[6:0] = 7'h0F;
      ST_ESTOP: sw_next[6:0] = 7'h07;
      default: sw_next[6:0] = 7'h00;
    endcase
    sw_next[`STA_PWR_DIS] = 1'b0;
    sw_next[`STA_WARN] = warning_present;
    sw_next[`STA_SYS_START] = system_started;
    sw_next[`STA_REMOTE] = remote_possible;
    sw_next[`STA_REF_REACHED] = reference_reached;
    sw_next[`STA_LIMIT] = limit_active;
    sw_next[15:12] = {digital_input_zero, digital_input_one,
                      digital_input_two, digital_input_three};
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sw_reg <= `WORD_RESET;
      act_reg <= `REF_RESET;
    end else begin
      sw_reg <= sw_next;
      act_reg <= actual_value;
    end
  end

  assign state_word = sw_reg;
  assign actual_word = act_reg;
endmodule

/* core/drive_word_params.svh */
// Constants for the drive command and state word logic
`ifndef DRIVE_WORD_PARAMS_SVH
`define DRIVE_WORD_PARAMS_SVH
// Command word bit positions
`define CMD_ACTIVATE 0
`define CMD_DIS_POWER 1
`define CMD_ESTOP_N 2
`define CMD_EN_OPER 3
`define CMD_TABLE_LSB 4
`define CMD_FAULT_RST 7
`define CMD_CURVE_SET 8
`define CMD_USER_LSB 9
`define CMD_DOUT_TWO 13
`define CMD_DOUT_ONE 14
`define CMD_DOUT_ZERO 15
// Status word bit positions
`define STA_READY 0
`define STA_ON 1
`define STA_OPER 2
`define STA_FAULT 3
`define STA_PWR_DIS 4
`define STA_ESTOP_N 5
`define STA_INHIBIT 6
`define STA_WARN 7
`define STA_SYS_START 8
`define STA_REMOTE 9
`define STA_REF_REACHED 10
`define STA_LIMIT 11
`define STA_DIN_THREE 12
// Setting codes
`define MODE_MIN 8'h01
`define MODE_MAX 8'h03
`define REF_SRC_TABLE 4'h7
`define CURVE_SRC_BUS 4'h6
`define USER_SRC_BUS 4'h3
`define OUT_FN_BUS 4'h5
// Reset values
`define WORD_RESET 16'h0000
`define REF_RESET 32'h00000000
`endif

/* core/drive_word_pkg.sv */
// Types for the drive command and state word logic
package drive_word_pkg;
  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_INHIBIT = 8'h02,
    ST_READY = 8'h04,
    ST_ON = 8'h08,
    ST_OPER = 8'h10,
    ST_FAULT = 8'h20,
    ST_FAULT_RESP = 8'h40,
    ST_ESTOP = 8'h80
  } drive_state_type;
  typedef logic [15:0] word_type;
  typedef logic [31:0] ref_type;
endpackage

/* core/rise_detect.sv */
// Rising edge detector for a synchronous level
`timescale 1ns/100ps
module rise_detect (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Level in, pulse out
  input wire logic level,
  output logic rise
);
  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = level;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise = level & ~prev_reg;
endmodule

/* tb/drive_word_props.sv */
// Checker for the drive command and state word logic
`timescale 1ns/100ps
module drive_word_props #(
  parameter int USER_SETS = 4
) (
  // Clock and reset
  input logic ref_clk,
  input logic rst_n,
  // Drive core feedback
  input logic warning_present,
  input logic remote_possible,
  input logic digital_input_zero,
  input logic digital_input_one,
  input logic digital_input_two,
  input logic digital_input_three,
  input logic [31:0] actual_value,
  // Design outputs
  input logic fault_clear,
  input logic table_ref_active,
  input logic bus_reference_valid,
  input logic power_stage_on,
  input drive_word_pkg::word_type state_word,
  input drive_word_pkg::ref_type actual_word
);
  import drive_word_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_PWR_DIS: assert property (!state_word[4])
    else $error("power disabled bit set");
  AST_WARN: assert property ($past(rst_n) |->
    state_word[7] == $past(warning_present)) else $error("warning bit");
  AST_REMOTE: assert property ($past(rst_n) |->
    state_word[9] == $past(remote_possible)) else $error("remote bit");
  AST_DIN: assert property ($past(rst_n) |->
    state_word[15:12] == $past({digital_input_zero, digital_input_one,
    digital_input_two, digital_input_three})) else $error("input bits");
  AST_ACTUAL: assert property ($past(rst_n) |->
    actual_word == $past(actual_value)) else $error("actual value");
  AST_CLR_PULSE: assert property (fault_clear |=> !fault_clear)
    else $error("fault clear longer than one cycle");
  AST_REF_BLOCK: assert property (table_ref_active |->
    !bus_reference_valid) else $error("bus reference during table mode");
  AST_PWR_ON: assert property ($rose(power_stage_on) |=>
    state_word[2:0] == 3'h7) else $error("power on without state");
  cover property (power_stage_on);
  cover property (fault_clear);
  cover property (table_ref_active);
endmodule
bind drive_control_status_word_logic drive_word_props #(
  .USER_SETS(USER_SETS)
) drive_word_props_inst (.ref_clk, .rst_n, .warning_present,
  .remote_possible, .digital_input_zero, .digital_input_one,
  .digital_input_two, .digital_input_three, .actual_value, .fault_clear,
  .table_ref_active, .bus_reference_valid, .power_stage_on, .state_word,
  .actual_word);

/* tb/bus_master_model.sv */
// Field bus master sending process-data messages
`timescale 1ns/100ps
module bus_master_model (
  // Clock
  input logic ref_clk,
  // Process data
  output logic cmd_valid,
  output logic [7:0] cmd_byte0,
  output logic [7:0] cmd_byte1,
  output logic [7:0] cmd_byte2,
  output logic [7:0] cmd_byte3,
  output logic [7:0] cmd_byte4,
  output logic [7:0] cmd_byte5
);
  logic [47:0] msg;
  assign {cmd_byte5, cmd_byte4, cmd_byte3} = msg[47:24];
  assign {cmd_byte2, cmd_byte1, cmd_byte0} = msg[23:0];
  initial begin
    cmd_valid = 1'b0;
    msg = 48'h0;
  end
  // Word in bytes 0..1, reference low byte first
  task automatic send(input logic [15:0] w, input logic [31:0] r);
    @(posedge ref_clk);
    #10;
    cmd_valid = 1'b1;
    msg = {r, w};
    @(posedge ref_clk);
    #10;
    cmd_valid = 1'b0;
    // Stale bytes inverted so nothing relies on them
    msg = ~msg;
  endtask
endmodule

/* tb/test_drive_control_status_word_logic.sv */
// Testbench for the drive command and state word logic
`timescale 1ns/100ps
module test_drive_control_status_word_logic;
  import drive_word_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid;
  logic [7:0] cmd_byte0, cmd_byte1, cmd_byte2, cmd_byte3, cmd_byte4;
  logic [7:0] cmd_byte5;
  logic [7:0] bus_control_mode_setting = 8'h02;
  logic [3:0] reference_source_setting = 4'h0;
  logic [3:0] curve_set_source_setting = 4'h6;
  logic [3:0] user_set_source_setting = 4'h3;
  logic [3:0] output_zero_function = 4'h5, output_one_function = 4'h5;
  logic [3:0] output_two_function = 4'h5;
  logic system_started = 1'b1, bus_reference_enabled = 1'b1;
  logic open_loop_volt_freq_mode = 1'b0, stop_ramp_enabled = 1'b1;
  logic fault_present = 1'b0, warning_present = 1'b0;
  logic remote_possible = 1'b0, reference_reached = 1'b0;
  logic limit_active = 1'b0, stop_done = 1'b0;
  logic [31:0] actual_value = 32'h0;
  logic digital_input_zero = 1'b0, digital_input_one = 1'b0;
  logic digital_input_two = 1'b0, digital_input_three = 1'b0;
  logic power_stage_on, ramp_stop, coast_stop, torque_brake;
  logic hold_zero_speed, fault_clear, bus_reference_valid;
  logic table_ref_active, curve_set_select, digital_output_zero;
  logic digital_output_one, digital_output_two;
  logic [31:0] bus_reference;
  logic [2:0] table_ref_index;
  logic [1:0] active_user_set;
  word_type state_word;
  ref_type actual_word;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  drive_control_status_word_logic drive_control_status_word_logic_inst (.*);
  bus_master_model bus_master_model_inst (.*);
  always #50 ref_clk = ~ref_clk;
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, about ten times the hundred or so cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Word is latched, then state moves, then the word shows it
  task automatic go(input logic [15:0] w, input logic [31:0] r = 32'h0);
    bus_master_model_inst.send(w, r);
    tick(3);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    tick(2);
    rst_n = 1'b1;
    tick(4);
    check(state_word, 16'h0140);
    bus_control_mode_setting = 8'h04;
    go(16'h0006);
    check(state_word, 16'h0140);
    bus_control_mode_setting = 8'h00;
    go(16'h0006);
    check(state_word, 16'h0140);
    bus_control_mode_setting = 8'h02;
    system_started = 1'b0;
    go(16'h0006);
    check(state_word, 16'h0040);
    system_started = 1'b1;
    bus_control_mode_setting = 8'h03;
    go(16'hBD56, 32'h12345678);
    check(state_word, 16'h0121);
    check(bus_reference, 32'h12345678);
    check(bus_reference_valid, 1'b1);
    check(table_ref_active, 1'b0);
    check(curve_set_select, 1'b1);
    check(active_user_set, 2'h2);
    check({digital_output_two, digital_output_one,
      digital_output_zero}, 3'h5);
    reference_source_setting = 4'h7;
    tick(2);
    check(table_ref_active, 1'b1);
    check(table_ref_index, 3'h5);
    check(bus_reference_valid, 1'b0);
    reference_source_setting = 4'h0;
    bus_reference_enabled = 1'b0;
    output_two_function = 4'h0;
    curve_set_source_setting = 4'h0;
    user_set_source_setting = 4'h0;
    go(16'hBA56, 32'h12345678);
    check(bus_reference_valid, 1'b0);
    check(digital_output_two, 1'b0);
    check(digital_output_zero, 1'b1);
    check(curve_set_select, 1'b1);
    check(active_user_set, 2'h2);
    bus_reference_enabled = 1'b1;
    curve_set_source_setting = 4'h6;
    user_set_source_setting = 4'h3;
    bus_control_mode_setting = 8'h01;
    go(16'h0007);
    check(state_word, 16'h0123);
    open_loop_volt_freq_mode = 1'b1;
    go(16'h000F);
    check(state_word, 16'h0123);
    go(16'h000F, 32'h00010000);
    check(state_word, 16'h0127);
    open_loop_volt_freq_mode = 1'b0;
    check(power_stage_on, 1'b1);
    go(16'h060F);
    check(active_user_set, 2'h0);
    go(16'h000B);
    check(state_word & 16'h006F, 16'h0007);
    check({ramp_stop, coast_stop, torque_brake}, 3'h4);
    stop_ramp_enabled = 1'b0;
    stop_done = 1'b1;
    tick(1);
    check({ramp_stop, coast_stop, torque_brake, hold_zero_speed},
      4'h5);
    stop_ramp_enabled = 1'b1;
    stop_done = 1'b0;
    go(16'h0000);
    check(state_word & 16'h004F, 16'h0040);
    stop_done = 1'b1;
    go(16'h0006);
    fault_present = 1'b1;
    tick(3);
    check(state_word & 16'h004F, 16'h0008);
    fault_present = 1'b0;
    bus_master_model_inst.send(16'h0080, 32'h0);
    // Pulse stands only until the next edge
    check(fault_clear, 1'b1);
    tick(2);
    check(state_word & 16'h004F, 16'h0040);
    fault_present = 1'b1;
    tick(3);
    fault_present = 1'b0;
    // Level held at one must not clear again
    go(16'h0080);
    check(state_word & 16'h004F, 16'h0008);
    // Reset edge while the fault still stands must not leave it
    fault_present = 1'b1;
    go(16'h0000);
    bus_master_model_inst.send(16'h0080, 32'h0);
    tick(2);
    check(state_word & 16'h004F, 16'h0008);
    fault_present = 1'b0;
    {warning_present, remote_possible} = 2'h3;
    {reference_reached, limit_active} = 2'h3;
    {digital_input_zero, digital_input_three} = 2'h3;
    actual_value = 32'hFFFE8000;
    tick(2);
    check(state_word & 16'hFF90, 16'h9F80);
    check(actual_word, 32'hFFFE8000);
    {digital_input_zero, digital_input_one} = 2'h1;
    {digital_input_two, digital_input_three} = 2'h2;
    tick(2);
    check(state_word & 16'hF000, 16'h6000);
    tally_and_finish;
  end
endmodule
